// >>> design/seesc_pkg.sv
// Purpose: Shared constants and types for the serial memory select-line control.
// Assumes: 20 MHz system clock; serial pins are asynchronous to it.
// Notes: Times are kept in their printed units and turned into cycle counts here.
package seesc_pkg;

  localparam int SEESC_CLK_HZ = 20000000;
  localparam int SEESC_DESEL_NS = 1000;
  localparam int SEESC_DESEL_CYC = (SEESC_DESEL_NS * (SEESC_CLK_HZ / 1000000) + 999) / 1000;
  localparam int SEESC_PROG_MS = 15;
  localparam int SEESC_PROG_CYC = SEESC_PROG_MS * (SEESC_CLK_HZ / 1000);

  localparam int SEESC_OP_W = 2;
  localparam int SEESC_ADDR_W = 8;
  localparam int SEESC_DATA_W = 16;
  localparam int SEESC_HDR_BITS = SEESC_OP_W + SEESC_ADDR_W;
  localparam int SEESC_CNT_W = 5;

  localparam logic [1:0] SEESC_OP_EXT = 2'h0;
  localparam logic [1:0] SEESC_OP_WRITE = 2'h1;
  localparam logic [1:0] SEESC_OP_READ = 2'h2;
  localparam logic [1:0] SEESC_OP_ERASE = 2'h3;
  localparam logic [1:0] SEESC_EXT_WDS = 2'h0;
  localparam logic [1:0] SEESC_EXT_WRALL = 2'h1;
  localparam logic [1:0] SEESC_EXT_ERAL = 2'h2;
  localparam logic [1:0] SEESC_EXT_WEN = 2'h3;

  typedef enum logic [2:0] {
    SEESC_IDLE = 3'h0,
    SEESC_HDR = 3'h1,
    SEESC_DATA = 3'h3,
    SEESC_DONE = 3'h2,
    SEESC_READ = 3'h6
  } seesc_state_type;

  typedef struct packed {
    logic select;
    logic sclk;
    logic sdata;
  } seesc_pins_type;

  typedef struct packed {
    logic [SEESC_OP_W-1:0] opcode;
    logic [SEESC_ADDR_W-1:0] addr;
    logic [SEESC_DATA_W-1:0] data;
  } seesc_cmd_type;

endpackage

// >>> design/seesc_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous pins.
// Assumes: Inputs are slow compared with clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
module seesc_sync
  import seesc_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// >>> design/seesc_top.sv
// Purpose: Select-line control of a small serial nonvolatile memory: framing, reset, programming start, status.
// Assumes: The master drives select, serial clock and serial data; all are synchronised to clk.
// Notes: The array itself is outside; a programming request made with writes enabled and not busy pulses cmd_valid with the captured command.
`timescale 1ns/100ps
module seesc_top
  import seesc_pkg::*;
#(
  parameter int PROG_CYCLES = SEESC_PROG_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic select_in,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  input wire logic [SEESC_DATA_W-1:0] read_data,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic [SEESC_ADDR_W-1:0] read_addr,
  output logic cmd_valid,
  output seesc_cmd_type cmd,
  output logic busy,
  output logic write_enabled
);

  seesc_pins_type pins_s;
  logic [2:0] pins_raw;
  logic [2:0] pins_sync;

  assign pins_raw = {select_in, serial_clock_in, serial_in};
  assign pins_s = pins_sync;

  seesc_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  function automatic logic is_prog(input logic [1:0] op, input logic [1:0] ext);
    is_prog = (op == SEESC_OP_WRITE) || (op == SEESC_OP_ERASE) ||
      ((op == SEESC_OP_EXT) && ((ext == SEESC_EXT_WRALL) || (ext == SEESC_EXT_ERAL)));
  endfunction

  seesc_state_type st_q, st_d;
  logic sel_q, sel_d, sck_q, sck_d;
  logic [SEESC_CNT_W-1:0] cnt_q, cnt_d;
  logic [SEESC_HDR_BITS-1:0] hdr_q, hdr_d;
  logic [SEESC_DATA_W-1:0] dat_q, dat_d;
  logic [SEESC_DATA_W:0] rsh_q, rsh_d;
  logic [7:0] dsl_q, dsl_d;
  logic reset_ok_q, reset_ok_d;
  logic wen_q, wen_d;
  logic [31:0] pcnt_q, pcnt_d;
  logic busy_q, busy_d;
  logic so_q, so_d, oe_n_q, oe_n_d, cv_q, cv_d;
  seesc_cmd_type cmd_q, cmd_d;
  logic [SEESC_ADDR_W-1:0] ra_q, ra_d;
  logic rld_q, rld_d;
  logic sel_rise, sel_fall, sck_rise;

  assign sel_rise = pins_s.select & ~sel_q;
  assign sel_fall = ~pins_s.select & sel_q;
  assign sck_rise = pins_s.sclk & ~sck_q & pins_s.select;

  always_comb
  begin
    st_d = st_q;
    sel_d = pins_s.select;
    sck_d = pins_s.sclk;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    dat_d = dat_q;
    rsh_d = rsh_q;
    dsl_d = dsl_q;
    reset_ok_d = reset_ok_q;
    wen_d = wen_q;
    pcnt_d = pcnt_q;
    busy_d = busy_q;
    so_d = so_q;
    oe_n_d = oe_n_q;
    cv_d = 1'b0;
    rld_d = 1'b0;
    cmd_d = cmd_q;
    ra_d = ra_q;
    if (!pins_s.select)
    begin
      oe_n_d = 1'b1;
      so_d = 1'b0;
      if (dsl_q < 8'(SEESC_DESEL_CYC))
        dsl_d = dsl_q + 8'h01;
      else
      begin
        reset_ok_d = 1'b1;
        hdr_d = '0;
        dat_d = '0;
        rsh_d = '0;
        cnt_d = '0;
      end
    end
    if (sel_rise)
    begin
      st_d = SEESC_IDLE;
      cnt_d = '0;
      dsl_d = '0;
      oe_n_d = 1'b0;
      so_d = ~busy_q;
    end
    else if (sck_rise && reset_ok_q)
    begin
      case (st_q)
        SEESC_IDLE:
        begin
          if (pins_s.sdata)
            st_d = SEESC_HDR;
        end
        SEESC_HDR:
        begin
          hdr_d = {hdr_q[SEESC_HDR_BITS-2:0], pins_s.sdata};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(SEESC_HDR_BITS - 1))
          begin
            cnt_d = '0;
            if (hdr_d[SEESC_HDR_BITS-1 -: 2] == SEESC_OP_READ)
            begin
              st_d = SEESC_READ;
              ra_d = hdr_d[SEESC_ADDR_W-1:0];
              rld_d = 1'b1;
              so_d = 1'b0;
            end
            else if (hdr_d[SEESC_HDR_BITS-1 -: 2] == SEESC_OP_WRITE ||
              (hdr_d[SEESC_HDR_BITS-1 -: 2] == SEESC_OP_EXT && hdr_d[SEESC_ADDR_W-1 -: 2] == SEESC_EXT_WRALL))
              st_d = SEESC_DATA;
            else
              st_d = SEESC_DONE;
          end
        end
        SEESC_DATA:
        begin
          dat_d = {dat_q[SEESC_DATA_W-2:0], pins_s.sdata};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(SEESC_DATA_W - 1))
            st_d = SEESC_DONE;
        end
        SEESC_READ:
        begin
          so_d = rsh_q[SEESC_DATA_W-1];
          rsh_d = {rsh_q[SEESC_DATA_W-1:0], 1'b0};
        end
        SEESC_DONE:
          st_d = SEESC_IDLE;
        default:
          st_d = SEESC_IDLE;
      endcase
    end
    // The word is loaded one cycle after its address is registered, so the array lookup sees the new address.
    if (rld_q)
      rsh_d = {1'b0, read_data};
    if (busy_q)
    begin
      if (pcnt_q == 32'h0)
        busy_d = 1'b0;
      else
        pcnt_d = pcnt_q - 32'h1;
      if (pins_s.select && !sel_rise)
        so_d = busy_d ? 1'b0 : 1'b1;
    end
    if (sel_fall)
    begin
      st_d = SEESC_IDLE;
      reset_ok_d = 1'b0;
      if (st_q == SEESC_DONE)
      begin
        if (hdr_q[SEESC_HDR_BITS-1 -: 2] == SEESC_OP_EXT && hdr_q[SEESC_ADDR_W-1 -: 2] == SEESC_EXT_WEN)
          wen_d = 1'b1;
        else if (hdr_q[SEESC_HDR_BITS-1 -: 2] == SEESC_OP_EXT && hdr_q[SEESC_ADDR_W-1 -: 2] == SEESC_EXT_WDS)
          wen_d = 1'b0;
        else if (wen_q && !busy_q && is_prog(hdr_q[SEESC_HDR_BITS-1 -: 2], hdr_q[SEESC_ADDR_W-1 -: 2]))
        begin
          busy_d = 1'b1;
          pcnt_d = 32'(PROG_CYCLES - 1);
          cv_d = 1'b1;
          cmd_d = '{opcode: hdr_q[SEESC_HDR_BITS-1 -: 2], addr: hdr_q[SEESC_ADDR_W-1:0], data: dat_q};
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= SEESC_IDLE;
      sel_q <= 1'b0;
      sck_q <= 1'b0;
      cnt_q <= '0;
      hdr_q <= '0;
      dat_q <= '0;
      rsh_q <= '0;
      dsl_q <= '0;
      reset_ok_q <= 1'b0;
      wen_q <= 1'b0;
      pcnt_q <= '0;
      busy_q <= 1'b0;
      so_q <= 1'b0;
      oe_n_q <= 1'b1;
      cv_q <= 1'b0;
      cmd_q <= '0;
      ra_q <= '0;
      rld_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      sel_q <= sel_d;
      sck_q <= sck_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      dat_q <= dat_d;
      rsh_q <= rsh_d;
      dsl_q <= dsl_d;
      reset_ok_q <= reset_ok_d;
      wen_q <= wen_d;
      pcnt_q <= pcnt_d;
      busy_q <= busy_d;
      so_q <= so_d;
      oe_n_q <= oe_n_d;
      cv_q <= cv_d;
      cmd_q <= cmd_d;
      ra_q <= ra_d;
      rld_q <= rld_d;
    end
  end

  assign serial_out = so_q;
  assign serial_out_oe_n = oe_n_q;
  assign read_addr = ra_q;
  assign cmd_valid = cv_q;
  assign cmd = cmd_q;
  assign busy = busy_q;
  assign write_enabled = wen_q;

  a_desel_release: assert property (@(posedge clk) disable iff (srst)
    !pins_s.select |=> serial_out_oe_n) else $error("Output driven while deselected.");
  a_select_drive: assert property (@(posedge clk) disable iff (srst)
    sel_rise |=> !serial_out_oe_n) else $error("Output not driven after select.");
  a_rise_resets: assert property (@(posedge clk) disable iff (srst)
    sel_rise |=> st_q == SEESC_IDLE) else $error("State not reset on select rise.");
  a_prog_start: assert property (@(posedge clk) disable iff (srst)
    cmd_valid |-> busy && $rose(busy)) else $error("Programming start not paired with busy.");
  a_busy_status: assert property (@(posedge clk) disable iff (srst)
    busy && sel_q && pins_s.select |=> serial_out == !busy) else $error("Busy not shown as low.");
  a_no_sck_desel: assert property (@(posedge clk) disable iff (srst)
    !pins_s.select && !sel_q |=> $stable(hdr_q) || hdr_q == '0) else $error("Shift while deselected.");
  a_desel_reset: assert property (@(posedge clk) disable iff (srst)
    !sel_q && dsl_q >= 8'(SEESC_DESEL_CYC) && !pins_s.select |=> reset_ok_q && hdr_q == '0)
    else $error("Registers not reset after deselect time.");
  a_sample_edge: assert property (@(posedge clk) disable iff (srst)
    st_q == SEESC_HDR && !sck_rise && !sel_rise && pins_s.select |=> $stable(hdr_q))
    else $error("Header shifted without clock rise.");

endmodule

// >>> dv/seesc_master.sv
// Purpose: Master model driving select, serial clock and serial data.
// Assumes: Eight clk cycles per serial clock period.
// Notes: The serial clock rests low outside frames.
`timescale 1ns/100ps
module seesc_master
(
  input wire logic clk,
  output logic select,
  output logic sclk,
  output logic sdata
);
  initial
  begin
    select = 1'b0;
    sclk = 1'b0;
    sdata = 1'b1;
  end

  task automatic sel(input logic v);
    @(posedge clk);
    select <= v;
    repeat (4) @(posedge clk);
  endtask

  // Data is set up four cycles before the rise and held four after it.
  task automatic bit_out(input logic b);
    sdata <= b;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
  endtask

  // Sends the first n bits of a left-aligned word, then deselects.
  task automatic frame(input logic [26:0] w, input int n);
    sel(1'b1);
    for (int i = 0; i < n; i++)
      bit_out(w[26-i]);
    select <= 1'b0;
    sdata <= ~sdata;
    repeat (24) @(posedge clk);
  endtask
endmodule

// >>> dv/seesc_top_tb.sv
// Purpose: Self-checking bench for the select-line control.
// Assumes: Programming time shortened to 50 cycles.
// Notes: Expected words come from the bench's own memory image.
`timescale 1ns/100ps
module seesc_top_tb
  import seesc_pkg::*;
;
  localparam int PROG = 50;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic serial_out, serial_out_oe_n, cmd_valid, busy, write_enabled;
  logic sel_w, sclk_w, sdata_w;
  logic [7:0] read_addr;
  logic [15:0] mem [256];
  seesc_cmd_type cmd, cmd_seen;
  int bad_count = 0;
  int num_checks = 0;
  int cv_count = 0;
  logic [7:0] a;
  logic [1:0] ops [4] = '{SEESC_OP_WRITE, SEESC_OP_ERASE, SEESC_OP_EXT, SEESC_OP_EXT};
  logic [1:0] tops [4] = '{2'h0, 2'h0, 2'h1, 2'h2};

  always #25 clk = ~clk;

  seesc_master u_seesc_master (.clk(clk), .select(sel_w), .sclk(sclk_w), .sdata(sdata_w));
  seesc_top #(.PROG_CYCLES(PROG)) u_seesc_top (.clk(clk), .srst(srst), .select_in(sel_w),
    .serial_clock_in(sclk_w), .serial_in(sdata_w), .read_data(mem[read_addr]), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .read_addr(read_addr), .cmd_valid(cmd_valid), .cmd(cmd),
    .busy(busy), .write_enabled(write_enabled));

  always @(posedge clk)
    if (cmd_valid === 1'b1)
    begin
      cv_count <= cv_count + 1;
      cmd_seen <= cmd;
    end

  task automatic check(input string what, input logic [25:0] seen, input logic [25:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic poll_ready;
    u_seesc_master.sel(1'b1);
    repeat (2) @(posedge clk);
    check("status_oe_n", 26'(serial_out_oe_n), 26'h0);
    check("status_busy", 26'({busy, serial_out}), 26'h2);
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
      @(posedge clk);
    repeat (6) @(posedge clk);
    check("status_ready", 26'(serial_out), 26'h1);
    u_seesc_master.sel(1'b0);
    repeat (2) @(posedge clk);
    check("released_oe_n", 26'(serial_out_oe_n), 26'h1);
    repeat (24) @(posedge clk);
  endtask

  task automatic prog(input logic [1:0] o, input logic [7:0] ad, input logic [15:0] dt, input int n, input int en);
    int c0;
    c0 = cv_count;
    u_seesc_master.frame({1'b1, o, ad, dt}, n);
    check("cmd_count", 26'(cv_count - c0), 26'(en));
    if (en != 0)
    begin
      check("cmd_head", 26'({cmd_seen.opcode, cmd_seen.addr}), 26'({o, ad}));
      if (n == 27)
        check("cmd_data", 26'(cmd_seen.data), 26'(dt));
      poll_ready;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end

  initial
  begin
    void'($urandom(32'h73E8));
    foreach (mem[i])
      mem[i] = 16'($urandom);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (30) @(posedge clk);
    check("reset_state", 26'({busy, write_enabled, serial_out_oe_n}), 26'h1);
    // A full enable pattern clocked while deselected must leave writes disabled.
    for (int i = 0; i < 11; i++)
      u_seesc_master.bit_out(i < 3 ? (i == 0) : (i < 5));
    check("ignored_enable", 26'({write_enabled, serial_out_oe_n}), 26'h1);
    prog(SEESC_OP_WRITE, 8'($urandom), 16'($urandom), 27, 0);
    u_seesc_master.frame({1'b1, SEESC_OP_READ, 24'h0}, 6);
    u_seesc_master.frame({1'b0, 1'b1, SEESC_OP_EXT, 8'hC0, 15'h0}, 12);
    check("enabled", 26'(write_enabled), 26'h1);
    for (int k = 0; k < 4; k++)
    begin
      a = 8'($urandom);
      if (k > 1)
        a[7:6] = tops[k];
      prog(ops[k], a, 16'($urandom), (k % 2 == 0) ? 27 : 11, 1);
    end
    a = {1'b0, 7'($urandom)};
    u_seesc_master.sel(1'b1);
    for (int i = 0; i < 11; i++)
      u_seesc_master.bit_out(i == 0 ? 1'b1 : (i < 3 ? SEESC_OP_READ[2-i] : a[10-i]));
    repeat (2) @(posedge clk);
    check("read_head", 26'({read_addr, serial_out_oe_n, serial_out}), 26'({a, 2'h0}));
    for (int i = 15; i >= 0; i--)
    begin
      u_seesc_master.bit_out(1'($urandom));
      repeat (2) @(posedge clk);
      check("read_bit", 26'(serial_out), 26'(mem[a][i]));
    end
    u_seesc_master.sel(1'b0);
    repeat (24) @(posedge clk);
    u_seesc_master.frame({1'b1, SEESC_OP_EXT, 8'h00, 16'h0}, 11);
    check("disabled", 26'(write_enabled), 26'h0);
    prog(SEESC_OP_WRITE, 8'($urandom), 16'($urandom), 27, 0);
    // An enable frame after a too short deselect must be refused.
    u_seesc_master.sel(1'b1);
    u_seesc_master.sel(1'b0);
    u_seesc_master.frame({1'b1, SEESC_OP_EXT, 8'hC0, 16'h0}, 11);
    check("short_deselect", 26'(write_enabled), 26'h0);
    tally_and_finish;
  end
endmodule
